// ==== hw/sepr_pkg.sv ====
// Shared constants and types of the serial EEPROM client read path.
// Assumes nothing of its surroundings; imported by every design module.
package sepr_pkg;

	// ==========================================================
	// Array and word layout
	localparam int ADDR_W = 9;
	localparam int DATA_W = 8;
	localparam int BYTE_BITS = 8;
	localparam logic [3:0] BIT_DONE = 4'h8;
	localparam logic [7:0] MEM_INIT = 8'hff;

	// ==========================================================
	// Control byte fields
	localparam logic [3:0] CTRL_CODE = 4'ha;
	localparam int CODE_MSB = 7;
	localparam int CODE_LSB = 4;
	localparam int BLK_BIT = 1;
	localparam int RW_BIT = 0;

	// ==========================================================
	// Timing
	localparam int SYS_CLK_MHZ = 10;
	localparam int WC_TIME_US = 100;
	localparam int WC_CYCLES_DFLT = WC_TIME_US * SYS_CLK_MHZ;
	localparam int FILT_LEN_DFLT = 3;
	localparam int BUF_DEPTH_DFLT = 2;

	// ==========================================================
	// Link state machine
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_CTRL,
		ST_ADDR,
		ST_WDATA,
		ST_ACK,
		ST_RLOAD,
		ST_RDATA,
		ST_RACK,
		ST_WAIT
	} sepr_state_t;

endpackage

// ==== hw/sepr_glitch_filter.sv ====
// Input synchroniser and spike filter for one bus line.
// Assumes the line is asynchronous to clk; output is registered.
`timescale 1ns/1ps
module sepr_glitch_filter #(
	parameter int FILT_LEN = 3,
	parameter logic INIT = 1'b1
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic din,
	output logic dout
);
	import sepr_pkg::*;

	localparam int CW = $clog2(FILT_LEN + 1);
	localparam logic [CW-1:0] LAST = CW'(FILT_LEN - 1);

	logic meta;
	logic sync;
	logic [CW-1:0] cnt;

	// Two-stage synchroniser; meta feeds sync only
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta <= INIT;
			sync <= INIT;
		end else begin
			meta <= din;
			sync <= meta;
		end
	end

	// Output follows only after FILT_LEN stable samples
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt <= '0;
			dout <= INIT;
		end else if (sync == dout) begin
			cnt <= '0;
		end else if (cnt == LAST) begin
			cnt <= '0;
			dout <= sync; // R13
		end else begin
			cnt <= cnt + CW'(1);
		end
	end

	AST_FILT_STABLE: assert property (@(posedge clk) disable iff (!rstn)
		(dout != $past(dout)) |-> $past(cnt) == LAST) // R13
		else $error("filter output moved before input was stable");

endmodule

// ==== hw/sepr_pair_buffer.sv ====
// Small FIFO with valid and ready on both sides, flip-flop storage.
// Assumes one clock; DEPTH is a power of two, two by default.
`timescale 1ns/1ps
module sepr_pair_buffer #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	import sepr_pkg::*;

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] store [DEPTH];
	logic [PW-1:0] wr_idx;
	logic [PW-1:0] rd_idx;
	logic [CW-1:0] count;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;

	// Honest full and empty flags
	assign in_ready = (count != CW'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = store[rd_idx];

	// Storage and indices
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < DEPTH; i++) store[i] <= '0;
			wr_idx <= '0;
			rd_idx <= '0;
		end else begin
			if (push) store[wr_idx] <= in_data;
			if (push) wr_idx <= wr_idx + PW'(1);
			if (pop) rd_idx <= rd_idx + PW'(1);
		end
	end

	// Occupancy
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) count <= '0;
		else if (push & ~pop) count <= count + CW'(1);
		else if (pop & ~push) count <= count - CW'(1);
	end

endmodule

// ==== hw/sepr_eeprom_client.sv ====
// Two-wire serial EEPROM client: read path, pointer and ack polling.
// Notes on behaviour
// [R1] No acknowledge at all while the internal write cycle runs.
// [R2] Stop closing a write with data starts the write cycle at once.
// [R3] Host polls with Start and write control byte; no ack means busy.
// [R4] After the write cycle ends the polling control byte is acknowledged.
// [R5] Read is framed like write, direction bit set to one.
// [R6] Pointer holds last location plus one for current-address reads.
// [R7] Read control byte is acknowledged, then the byte at pointer shifted.
// [R8] After the host's no-ack and Stop the device stops driving data.
// [R9] Word address loads the pointer; repeated Start then writes nothing.
// [R10] Host resends control byte with direction one after repeated Start.
// [R11] Host acknowledge of a read byte sends the next sequential byte.
// [R12] Pointer advances by one after every byte access.
// [R13] Both bus inputs are filtered against short spikes.
// [R14] Control byte: code 1010, two ignored bits, block bit, direction.
// [R15] Host no-ack ends a read; data line is released high.
// [R16] Word address is a full byte loaded straight into the pointer.
// [R17] Sequential pointer wraps from the top location back to zero.
// Assumes: scl and sda come from pins; link_clk is a free-running
// sampling clock several times faster than the bus clock.
`timescale 1ns/1ps
module sepr_eeprom_client #(
	parameter int WC_CYCLES = sepr_pkg::WC_CYCLES_DFLT,
	parameter int FILT_LEN = sepr_pkg::FILT_LEN_DFLT,
	parameter int BUF_DEPTH = sepr_pkg::BUF_DEPTH_DFLT
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic link_clk,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic wr_valid,
	input wire logic wr_ready,
	output logic [sepr_pkg::ADDR_W-1:0] wr_addr,
	output logic [sepr_pkg::DATA_W-1:0] wr_data,
	output logic wc_busy
);
	import sepr_pkg::*;

	localparam int WORD_W = ADDR_W + DATA_W;
	localparam int MEM_SIZE = 1 << ADDR_W;
	localparam int TW = $clog2(WC_CYCLES + 1);
	localparam logic [TW-1:0] WC_LAST = TW'(WC_CYCLES - 1);
	localparam logic [ADDR_W-1:0] ADDR_TOP = '1;

	// Pointer step with natural wrap at the top of the array
	function automatic logic [ADDR_W-1:0] next_addr(
		input logic [ADDR_W-1:0] a);
		return a + ADDR_W'(1);
	endfunction

	// ==========================================================
	// Link domain: filtering and bus conditions
	logic scl_f;
	logic sda_f;
	logic scl_q;
	logic sda_q;

	sepr_glitch_filter #(.FILT_LEN(FILT_LEN), .INIT(1'b1)) u_scl_filt (
		.clk(link_clk),
		.rstn(rstn),
		.din(scl_in),
		.dout(scl_f)
	);

	sepr_glitch_filter #(.FILT_LEN(FILT_LEN), .INIT(1'b1)) u_sda_filt (
		.clk(link_clk),
		.rstn(rstn),
		.din(sda_in),
		.dout(sda_f)
	);

	// Previous filtered levels for edge detection
	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_f;
			sda_q <= sda_f;
		end
	end

	sepr_state_t state;
	sepr_state_t ack_next;
	logic [3:0] bitcnt;
	logic [7:0] shreg;
	logic [7:0] txreg;
	logic [ADDR_W-1:0] ptr;
	logic blk;
	logic wrote;
	logic wc_req;
	logic slot_req;
	logic [WORD_W-1:0] slot_word;
	logic ack_m;
	logic ack_s;
	logic done_m;
	logic done_s;
	logic [DATA_W-1:0] mem [MEM_SIZE];

	// Bus events and byte decode
	wire scl_rise = scl_f & ~scl_q;
	wire scl_fall = ~scl_f & scl_q;
	wire start_det = scl_f & scl_q & sda_q & ~sda_f;
	wire stop_det = scl_f & scl_q & ~sda_q & sda_f;
	wire byte_end = scl_fall & (bitcnt == BIT_DONE);
	wire rx_state = (state == ST_CTRL) | (state == ST_ADDR) |
		(state == ST_WDATA);
	wire counting = rx_state | (state == ST_RDATA);
	wire code_ok = (shreg[CODE_MSB:CODE_LSB] == CTRL_CODE);
	wire busy = wc_req | done_s;
	wire slot_free = ~slot_req & ~ack_s;
	wire [DATA_W-1:0] mem_rd = mem[ptr];
	wire [ADDR_W-1:0] ptr_inc = next_addr(ptr);
	wire addr_load = (state == ST_ADDR) & byte_end;
	wire wr_take = (state == ST_WDATA) & byte_end & slot_free;
	wire rd_done = (state == ST_RDATA) & byte_end;
	wire ctrl_end = (state == ST_CTRL) & byte_end;

	// Open-drain data: only ever pulls low
	assign sda_out = 1'b0;

	// ==========================================================
	// Link domain: bit counter and receive shifter
	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) bitcnt <= '0;
		else if (start_det | byte_end) bitcnt <= '0;
		else if ((state == ST_RLOAD) & scl_fall) bitcnt <= '0;
		else if (scl_rise & counting) bitcnt <= bitcnt + 4'h1;
	end

	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) shreg <= '0;
		else if (scl_rise & rx_state) shreg <= {shreg[6:0], sda_f};
	end

	// ==========================================================
	// Link domain: protocol state machine and data line
	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			state <= ST_IDLE;
			ack_next <= ST_IDLE;
			sda_oe <= 1'b0;
			txreg <= '0;
			blk <= 1'b0;
		end else if (stop_det) begin
			state <= ST_IDLE; // R8
			sda_oe <= 1'b0; // R8
		end else if (start_det) begin
			state <= ST_CTRL; // R9 R10
			sda_oe <= 1'b0;
		end else begin
			case (state)
			ST_CTRL: begin
				if (byte_end) begin
					blk <= shreg[BLK_BIT]; // R14
					if (code_ok & ~busy) begin
						sda_oe <= 1'b1; // R4 R7
						ack_next <= ST_ADDR;
						// Direction bit picks read or write framing
						state <= shreg[RW_BIT] ? ST_RLOAD : ST_ACK; // R5
					end else begin
						state <= ST_WAIT; // R1 R3
					end
				end
			end
			ST_ADDR: begin
				if (byte_end) begin
					sda_oe <= ~busy; // R1
					ack_next <= ST_WDATA;
					state <= ST_ACK;
				end
			end
			ST_WDATA: begin
				if (byte_end) begin
					sda_oe <= slot_free;
					ack_next <= ST_WDATA;
					state <= slot_free ? ST_ACK : ST_WAIT;
				end
			end
			ST_ACK: begin
				if (scl_fall) begin
					sda_oe <= 1'b0;
					state <= ack_next;
				end
			end
			ST_RLOAD: begin
				// End of acknowledge bit: first data bit goes out
				if (scl_fall) begin
					txreg <= mem_rd; // R7 R11
					sda_oe <= ~mem_rd[7];
					state <= ST_RDATA;
				end
			end
			ST_RDATA: begin
				if (byte_end) begin
					sda_oe <= 1'b0; // R15
					state <= ST_RACK;
				end else if (scl_fall) begin
					sda_oe <= ~txreg[6];
					txreg <= {txreg[6:0], 1'b0};
				end
			end
			ST_RACK: begin
				// Host ack continues, host no-ack keeps the line released since the byte end
				if (scl_rise) state <= sda_f ? ST_WAIT : ST_RLOAD; // R11 R15
			end
			default: begin
				state <= state;
			end
			endcase
		end
	end

	// ==========================================================
	// Link domain: address pointer and array
	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) ptr <= '0;
		else if (addr_load) ptr <= {blk, shreg}; // R9 R16
		else if (wr_take | rd_done) ptr <= ptr_inc; // R6 R12 R17
	end

	// Written bytes land in the array as they are acknowledged
	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < MEM_SIZE; i++) mem[i] <= MEM_INIT;
		end else if (wr_take) begin
			mem[ptr] <= shreg;
		end
	end

	// Write data byte taken; only a Stop turns it into a write cycle
	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) wrote <= 1'b0;
		else if (wr_take) wrote <= 1'b1;
		else if (stop_det) wrote <= 1'b0;
	end

	// Write-cycle request, held until the timer side reports done
	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) wc_req <= 1'b0;
		else if (stop_det & wrote) wc_req <= 1'b1; // R2
		else if (done_s) wc_req <= 1'b0;
	end

	// Word slot toward the system domain, four-phase handshake
	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) slot_req <= 1'b0;
		else if (wr_take) slot_req <= 1'b1;
		else if (ack_s) slot_req <= 1'b0;
	end

	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) slot_word <= '0;
		else if (wr_take) slot_word <= {ptr, shreg};
	end

	// ==========================================================
	// System domain: synchronisers
	logic req_m;
	logic req_s;
	logic wcreq_m;
	logic wcreq_s;
	logic ack_sys;
	logic done_sys;
	logic [TW-1:0] timer;
	logic buf_ready;
	logic [WORD_W-1:0] buf_out;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			req_m <= 1'b0;
			req_s <= 1'b0;
			wcreq_m <= 1'b0;
			wcreq_s <= 1'b0;
		end else begin
			req_m <= slot_req;
			req_s <= req_m;
			wcreq_m <= wc_req;
			wcreq_s <= wcreq_m;
		end
	end

	// Link-side view of the system answers
	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			ack_m <= 1'b0;
			ack_s <= 1'b0;
			done_m <= 1'b0;
			done_s <= 1'b0;
		end else begin
			ack_m <= ack_sys;
			ack_s <= ack_m;
			done_m <= done_sys;
			done_s <= done_m;
		end
	end

	// ==========================================================
	// System domain: written-word stream through the buffer
	wire push = req_s & ~ack_sys & buf_ready;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) ack_sys <= 1'b0;
		else if (push) ack_sys <= 1'b1;
		else if (~req_s) ack_sys <= 1'b0;
	end

	sepr_pair_buffer #(.WIDTH(WORD_W), .DEPTH(BUF_DEPTH)) u_buf (
		.clk(sys_clk),
		.rstn(rstn),
		.in_valid(req_s & ~ack_sys),
		.in_ready(buf_ready),
		.in_data(slot_word),
		.out_valid(wr_valid),
		.out_ready(wr_ready),
		.out_data(buf_out)
	);

	assign wr_addr = buf_out[WORD_W-1:DATA_W];
	assign wr_data = buf_out[DATA_W-1:0];

	// ==========================================================
	// System domain: self-timed write cycle
	wire wc_run = wcreq_s & ~done_sys;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) timer <= '0;
		else if (~wc_run | (timer == WC_LAST)) timer <= '0;
		else timer <= timer + TW'(1);
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) done_sys <= 1'b0;
		else if (wc_run & (timer == WC_LAST)) done_sys <= 1'b1;
		else if (~wcreq_s) done_sys <= 1'b0;
	end

	assign wc_busy = wcreq_s;

	// ==========================================================
	// Checks
	AST_NO_ACK_BUSY: assert property ( // R1
		@(posedge link_clk) disable iff (!rstn)
		ctrl_end & busy & ~stop_det & ~start_det |=> !sda_oe ##1 !sda_oe)
		else $error("acknowledge driven during write cycle");

	AST_WC_START: assert property ( // R2
		@(posedge link_clk) disable iff (!rstn)
		stop_det & wrote |=> wc_req && state == ST_IDLE)
		else $error("write cycle not started at stop");

	AST_POLL_ACK: assert property ( // R4
		@(posedge link_clk) disable iff (!rstn)
		ctrl_end & code_ok & ~busy & ~shreg[RW_BIT] |=>
		sda_oe && state == ST_ACK)
		else $error("idle device did not acknowledge control byte");

	AST_READ_DIR: assert property ( // R7
		@(posedge link_clk) disable iff (!rstn)
		ctrl_end & code_ok & ~busy & shreg[RW_BIT] |=>
		state == ST_RLOAD && sda_oe)
		else $error("read control byte not taken");

	AST_PTR_STEP: assert property ( // R12
		@(posedge link_clk) disable iff (!rstn)
		rd_done | wr_take |=> ptr == next_addr($past(ptr)))
		else $error("pointer did not advance by one");

	AST_PTR_WRAP: assert property ( // R17
		@(posedge link_clk) disable iff (!rstn)
		rd_done & (ptr == ADDR_TOP) |=> ptr == '0)
		else $error("pointer did not wrap to zero");

	AST_ADDR_LOAD: assert property ( // R16
		@(posedge link_clk) disable iff (!rstn)
		addr_load & ~stop_det |=> ptr == {$past(blk), $past(shreg)}
		&& wrote == $past(wrote))
		else $error("word address not loaded");

	AST_STOP_RELEASE: assert property ( // R8
		@(posedge link_clk) disable iff (!rstn)
		stop_det |=> !sda_oe && state == ST_IDLE)
		else $error("data line still driven after stop");

	AST_NACK_RELEASE: assert property ( // R15
		@(posedge link_clk) disable iff (!rstn)
		(state == ST_RACK) & scl_rise & sda_f & ~stop_det |=>
		state == ST_WAIT && !sda_oe)
		else $error("line not released after host no-ack");

	AST_SEQ_LOAD: assert property ( // R11
		@(posedge link_clk) disable iff (!rstn)
		(state == ST_RLOAD) & scl_fall & ~stop_det & ~start_det |=>
		txreg == $past(mem_rd) && sda_oe == ~$past(mem_rd[7]))
		else $error("next read byte not loaded from pointer");

	AST_WC_TIME: assert property ( // R2
		@(posedge sys_clk) disable iff (!rstn)
		$rose(done_sys) |-> $past(timer) == WC_LAST && $past(wcreq_s))
		else $error("write cycle length wrong");

endmodule

// ==== verification/sepr_bus_host.sv ====
// Bus host model: drives the serial clock, data, Start and Stop.
// Assumes the bench resolves the open-drain data wire into sda_line.
`timescale 1ns/1ps
module sepr_bus_host #(
	parameter int HALF = 32
) (
	input wire logic clk,
	input wire logic sda_line,
	output logic scl,
	output logic sda
);
	// ==========================================================
	// Idle bus and pacing
	// Both lines released high until the first transfer
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end

	// Levels only change just after a clock edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// ==========================================================
	// Conditions and bits
	// Start from idle, or repeated Start with the clock low
	task automatic start();
		sda <= 1'b1;
		tick(HALF / 2);
		scl <= 1'b1;
		tick(HALF);
		sda <= 1'b0;
		tick(HALF / 2);
		scl <= 1'b0;
	endtask

	// Data low in the clock low phase, then rising while clock high
	task automatic stop();
		tick(HALF / 2);
		sda <= 1'b0;
		tick(HALF / 2);
		scl <= 1'b1;
		tick(HALF);
		sda <= 1'b1;
		tick(HALF);
	endtask

	// One bit: set mid-low, sampled mid-high; optional short spike
	task automatic bit_io(input logic b, input logic spike, output logic s);
		tick(HALF / 2);
		sda <= b;
		tick(HALF / 2);
		scl <= 1'b1;
		tick(HALF / 4);
		if (spike) begin
			sda <= ~b;
			tick(2);
			sda <= b;
		end
		tick(HALF / 4);
		s = sda_line;
		tick(HALF / 2);
		scl <= 1'b0;
	endtask

	// ==========================================================
	// Bytes
	// Byte out, most significant bit first; returns acknowledge
	task automatic put_byte(input logic [7:0] d, input logic spike,
		output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], spike && i == 3, s);
		end
		bit_io(1'b1, 1'b0, s);
		ack = ~s;
	endtask

	// Byte in with the line released; acknowledge only if more wanted
	task automatic get_byte(input logic more, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, 1'b0, s);
			d[i] = s;
		end
		bit_io(~more, 1'b0, s);
	endtask
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench of the serial EEPROM client read path.
// Assumes sepr_pkg, the design files and the bus host model.
`timescale 1ns/1ps
module tb_top;
	import sepr_pkg::*;
	localparam int WC = 2000;
	logic sys_clk = 1'b0;
	logic link_clk = 1'b0;
	logic rstn = 1'b0;
	logic wr_ready = 1'b0;
	logic stall = 1'b0;
	logic scl_h, sda_h, sda_out, sda_oe, sda_line, wr_valid, wc_busy, ack;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic [ADDR_W+DATA_W-1:0] exp_q[$];
	logic [7:0] mem_m [0:511];
	logic [8:0] ptr_m = 9'h000;
	logic [7:0] rd;
	int miscompares = 0;
	int compares = 0;
	int n;

	// ==========================================================
	// Clocks, wiring, instances
	initial begin
		forever #50 sys_clk = ~sys_clk;
	end
	initial begin
		#37;
		forever #80 link_clk = ~link_clk;
	end
	// Open-drain data wire with pull-up
	assign sda_line = (sda_oe ? sda_out : 1'b1) & sda_h;

	sepr_eeprom_client #(.WC_CYCLES(WC)) dut_u (.sys_clk(sys_clk),
		.rstn(rstn), .link_clk(link_clk), .scl_in(scl_h),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
		.wr_data(wr_data), .wc_busy(wc_busy));
	sepr_bus_host host_u (.clk(sys_clk), .sda_line(sda_line),
		.scl(scl_h), .sda(sda_h));

	// ==========================================================
	// Comparison and verdict
	task automatic chk_word(input string nm, input logic [16:0] e,
		input logic [16:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_byte(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		chk_word(nm, {9'h000, e}, {9'h000, g});
	endtask
	task automatic chk_bit(input string nm, input logic e, input logic g);
		chk_word(nm, {16'h0000, e}, {16'h0000, g});
	endtask
	task automatic summarize();
		if (miscompares == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ==========================================================
	// Stream sink and its checker
	// Random stalls unless a full-buffer test holds ready low
	always @(posedge sys_clk) begin
		wr_ready <= ~stall & ($urandom_range(3) != 0);
	end
	// Each taken word is matched against the oldest expected word
	always @(posedge sys_clk) begin
		if (rstn === 1'b1 && wr_valid === 1'b1 && wr_ready === 1'b1)
			chk_word("stream word", exp_q.size() > 0 ? exp_q.pop_front()
				: 'x, {wr_addr, wr_data});
	end
	// Hang guard
	initial begin
		repeat (60000) @(posedge sys_clk);
		miscompares++;
		summarize();
	end

	// ==========================================================
	// Transaction tasks
	// Write cnt random bytes from {blk, a}; returns bytes acknowledged
	task automatic wr_seq(input logic blk, input logic [7:0] a,
		input int cnt, output int got);
		logic [8:0] p;
		logic [7:0] d;
		p = {blk, a};
		got = 0;
		host_u.start();
		host_u.put_byte({4'ha, 2'b00, blk, 1'b0}, 1'b0, ack);
		host_u.put_byte(a, 1'b0, ack);
		chk_bit("address ack", 1'b1, ack);
		for (int i = 0; i < cnt; i++) begin
			d = 8'($urandom);
			exp_q.push_back({p, d});
			host_u.put_byte(d, i == 0, ack);
			if (ack !== 1'b1) begin
				void'(exp_q.pop_back());
				break;
			end
			mem_m[p] = d;
			p++;
			got++;
		end
		host_u.stop();
	endtask

	// Read cnt bytes at the pointer, last one left unacknowledged
	task automatic rd_cur(input logic [7:0] c, input int cnt);
		host_u.start();
		host_u.put_byte(c, 1'b0, ack);
		chk_bit("read control ack", 1'b1, ack);
		for (int i = 0; i < cnt; i++) begin
			host_u.get_byte(i < cnt - 1, rd);
			chk_byte("read data", mem_m[ptr_m], rd);
			ptr_m++;
		end
		chk_bit("released after no-ack", 1'b0, sda_oe);
		host_u.stop();
		chk_bit("line released", 1'b0, sda_oe);
	endtask

	// Set the pointer by a write without data, then repeated Start
	task automatic rd_rand(input logic blk, input logic [7:0] a,
		input int cnt);
		host_u.start();
		host_u.put_byte({4'ha, 2'b00, blk, 1'b0}, 1'b0, ack);
		host_u.put_byte(a, 1'b0, ack);
		chk_bit("word address ack", 1'b1, ack);
		ptr_m = {blk, a};
		rd_cur(8'ha1, cnt);
		repeat (20) @(negedge sys_clk);
		chk_bit("no write cycle", 1'b0, wc_busy);
	endtask

	// Write cycle must start, refuse polls, then answer one
	task automatic poll();
		for (int i = 0; i < 50 && wc_busy !== 1'b1; i++)
			@(negedge sys_clk);
		chk_bit("write busy", 1'b1, wc_busy);
		for (int i = 0; i < 20; i++) begin
			host_u.start();
			host_u.put_byte(8'ha0, 1'b0, ack);
			host_u.stop();
			if (i == 0)
				chk_bit("busy poll ack", 1'b0, ack);
			if (ack === 1'b1)
				break;
		end
		chk_bit("done poll ack", 1'b1, ack);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(4609));
		foreach (mem_m[i])
			mem_m[i] = MEM_INIT;
		repeat (6) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (20) @(posedge sys_clk);
		rd_cur(8'had, 2);
		host_u.start();
		host_u.put_byte(8'h51, 1'b0, ack);
		host_u.stop();
		chk_bit("foreign code ack", 1'b0, ack);
		wr_seq(1'b1, 8'hff, 3, n);
		chk_byte("bytes stored", 8'h03, 8'(n));
		poll();
		rd_rand(1'b1, 8'hff, 2);
		rd_cur(8'ha1, 1);
		stall <= 1'b1;
		wr_seq(1'b0, 8'h10, 6, n);
		chk_byte("full buffer refuses", 8'(BUF_DEPTH_DFLT + 1), 8'(n));
		stall <= 1'b0;
		poll();
		rd_rand(1'b0, 8'h10, n + 1);
		for (int i = 0; i < 200 && exp_q.size() > 0; i++)
			@(posedge sys_clk);
		chk_byte("words left", 8'h00, 8'(exp_q.size()));
		summarize();
	end
endmodule
